// ===== rtl/ccr_pkg.sv
package ccr_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [9:0] OFS_SERIAL_PORT_CONFIG  = 10'h000;
  localparam logic [9:0] OFS_PART_IDENTIFIER     = 10'h003;
  localparam logic [9:0] OFS_READBACK_SELECT     = 10'h004;
  localparam logic [9:0] OFS_VCO_DIVIDE_RATIO    = 10'h1E0;
  localparam logic [9:0] OFS_CLOCK_INPUT_CONTROL = 10'h1E1;
  localparam logic [9:0] OFS_POWERDOWN_AND_SYNC  = 10'h230;
  localparam logic [9:0] OFS_UPDATE_STROBE       = 10'h232;

  // Buffered registers, index order 0..2
  localparam int NUM_BUF = 3;
  localparam logic [NUM_BUF-1:0][9:0] BUF_OFS = {
    OFS_POWERDOWN_AND_SYNC,
    OFS_CLOCK_INPUT_CONTROL,
    OFS_VCO_DIVIDE_RATIO
  };
  localparam int IDX_VCO = 0;
  localparam int IDX_CLK = 1;
  localparam int IDX_PDS = 2;

  // Reset values
  localparam logic [7:0] RST_SERIAL_PORT_CONFIG  = 8'h18;
  localparam logic [7:0] RST_READBACK_SELECT     = 8'h00;
  localparam logic [7:0] RST_VCO_DIVIDE_RATIO    = 8'h02;
  localparam logic [7:0] RST_CLOCK_INPUT_CONTROL = 8'h00;
  localparam logic [7:0] RST_POWERDOWN_AND_SYNC  = 8'h00;
  localparam logic [7:0] RST_UPDATE_STROBE       = 8'h00;
  localparam logic [NUM_BUF-1:0][7:0] BUF_RST = {
    RST_POWERDOWN_AND_SYNC,
    RST_CLOCK_INPUT_CONTROL,
    RST_VCO_DIVIDE_RATIO
  };

  // Arbitrary identification value, not tied to any real part
  localparam logic [7:0] PART_IDENTIFIER_DEFAULT = 8'h5A;

  // Serial port configuration fields
  localparam int CFG_UNIDIR     = 0;
  localparam int CFG_LSB_FIRST  = 1;
  localparam int CFG_SOFT_RESET = 2;
  localparam int CFG_LONG_INSTR = 3;

  // Other fields
  localparam int RBS_ACTIVE       = 0;
  localparam int UPD_BIT          = 0;
  localparam int CLK_SKIP_DIVIDE  = 0;
  localparam int CLK_POWERDOWN    = 4;
  localparam int PDS_SOFT_SYNC    = 0;
  localparam int PDS_PD_DIST_REF  = 1;
  localparam int PDS_PD_SYNC      = 2;

  localparam logic [7:0] DATA_ZERO = 8'h00;

endpackage

// ===== rtl/ccr_buffered_reg.sv
`timescale 1ns/1ps
module ccr_buffered_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       soft_reset_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       update_i,
  output logic      [7:0] buffer_o,
  output logic      [7:0] active_o
);

  logic [7:0] buffer;
  logic [7:0] active;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_reset_i) begin
      buffer <= RESET_VALUE;
    end else if (wr_i) begin
      buffer <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_reset_i) begin
      active <= RESET_VALUE;
    end else if (update_i) begin
      active <= buffer;
    end
  end

  assign buffer_o = buffer;
  assign active_o = active;

endmodule

// ===== rtl/ccr_regs.sv
// How it works
// - Only long 16-bit instructions; long-mode bit is held at one.
// - Config soft-reset bit holds all other registers at defaults until cleared.
// - Config bit 1 picks LSB first with incrementing address, else MSB.
// - Config bit 0 picks read pin: shared data pin or separate output.
// - Read-only part identifier returns a fixed code; writes ignored.
// - Readback select bit 0 returns active values, else buffered ones.
// - Writing one to update bit triggers update; bit then clears itself.
`timescale 1ns/1ps
module ccr_regs #(
  parameter logic [7:0] PART_IDENTIFIER = ccr_pkg::PART_IDENTIFIER_DEFAULT
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [9:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  input  wire logic       read_bit_i,
  input  wire logic       read_bit_en_i,
  output logic            data_pin_o,
  output logic            data_pin_oe_o,
  output logic            serial_data_out_pin_o,
  output logic            serial_data_out_pin_oe_o,
  output logic            long_instruction_o,
  output logic            lsb_first_o,
  output logic            address_increment_o,
  output logic            unidirectional_read_select_o,
  output logic            soft_reset_o,
  output logic            update_pulse_o,
  output logic      [7:0] vco_divide_ratio_o,
  output logic            skip_oscillator_divide_o,
  output logic            clock_input_powerdown_o,
  output logic      [7:0] powerdown_and_sync_o,
  output logic            soft_sync_o,
  output logic            powerdown_distribution_ref_o,
  output logic            powerdown_sync_o
);

  logic [7:0] serial_port_config;
  logic [7:0] readback_select;
  logic [7:0] update_strobe;
  logic [7:0] rdata;
  logic       rvalid;
  logic       sdio_out;
  logic       sdio_oe;
  logic       sdo_out;
  logic       sdo_oe;

  logic [7:0] next_serial_port_config;
  logic [7:0] next_update_strobe;

  logic [ccr_pkg::NUM_BUF-1:0][7:0] buf_val;
  logic [ccr_pkg::NUM_BUF-1:0][7:0] act_val;
  logic [ccr_pkg::NUM_BUF-1:0]      buf_wr;
  logic [ccr_pkg::NUM_BUF-1:0]      buf_hit;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
    hit = (a == ofs);
  endfunction

  // Decode
  wire soft_reset   = serial_port_config[ccr_pkg::CFG_SOFT_RESET];
  wire wr_cfg       = reg_wr_i && hit(reg_addr_i,
                                      ccr_pkg::OFS_SERIAL_PORT_CONFIG);
  wire wr_rbs       = reg_wr_i && hit(reg_addr_i,
                                      ccr_pkg::OFS_READBACK_SELECT);
  wire wr_upd       = reg_wr_i && hit(reg_addr_i,
                                      ccr_pkg::OFS_UPDATE_STROBE);
  wire update_fire  = update_strobe[ccr_pkg::UPD_BIT];
  wire read_active  = readback_select[ccr_pkg::RBS_ACTIVE];
  wire unidir       = serial_port_config[ccr_pkg::CFG_UNIDIR];

  // Long mode cannot be left; the bit always stores one
  always_comb begin
    next_serial_port_config = reg_wdata_i;
    next_serial_port_config[ccr_pkg::CFG_LONG_INSTR] = 1'b1;
  end

  // Soft reset is itself a config bit, so config is never held by it
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      serial_port_config <= ccr_pkg::RST_SERIAL_PORT_CONFIG;
    end else if (wr_cfg) begin
      serial_port_config <= next_serial_port_config;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_reset) begin
      readback_select <= ccr_pkg::RST_READBACK_SELECT;
    end else if (wr_rbs) begin
      readback_select <= reg_wdata_i;
    end
  end

  // Update bit: set by write, cleared one cycle later by hardware
  always_comb begin
    next_update_strobe = ccr_pkg::DATA_ZERO;
    if (wr_upd && reg_wdata_i[ccr_pkg::UPD_BIT]) begin
      next_update_strobe[ccr_pkg::UPD_BIT] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_reset) begin
      update_strobe <= ccr_pkg::RST_UPDATE_STROBE;
    end else begin
      update_strobe <= next_update_strobe;
    end
  end

  // Buffered / active register pairs
  genvar g;
  generate
    for (g = 0; g < ccr_pkg::NUM_BUF; g++) begin : g_buf
      assign buf_hit[g] = hit(reg_addr_i, ccr_pkg::BUF_OFS[g]);
      assign buf_wr[g]  = reg_wr_i && buf_hit[g];
      ccr_buffered_reg #(
        .RESET_VALUE (ccr_pkg::BUF_RST[g])
      ) u_reg (
        .ref_clk_i    (ref_clk_i),
        .rst_n_i      (rst_n_i),
        .soft_reset_i (soft_reset),
        .wr_i         (buf_wr[g]),
        .wdata_i      (reg_wdata_i),
        .update_i     (update_fire),
        .buffer_o     (buf_val[g]),
        .active_o     (act_val[g])
      );
    end
  endgenerate

  // Read mux; unmapped offsets read zero
  logic [7:0] read_mux;
  always_comb begin
    read_mux = ccr_pkg::DATA_ZERO;
    if (hit(reg_addr_i, ccr_pkg::OFS_SERIAL_PORT_CONFIG)) begin
      read_mux = serial_port_config;
    end
    if (hit(reg_addr_i, ccr_pkg::OFS_PART_IDENTIFIER)) begin
      read_mux = PART_IDENTIFIER;
    end
    if (hit(reg_addr_i, ccr_pkg::OFS_READBACK_SELECT)) begin
      read_mux = readback_select;
    end
    if (hit(reg_addr_i, ccr_pkg::OFS_UPDATE_STROBE)) begin
      read_mux = update_strobe;
    end
    for (int i = 0; i < ccr_pkg::NUM_BUF; i++) begin
      if (buf_hit[i]) begin
        read_mux = read_active ? act_val[i] : buf_val[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rdata  <= ccr_pkg::DATA_ZERO;
      rvalid <= 1'b0;
    end else begin
      rvalid <= reg_rd_i;
      if (reg_rd_i) begin
        rdata <= read_mux;
      end
    end
  end

  // Read data pins; the unused pin is released, never driven low
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sdio_out <= 1'b0;
      sdio_oe  <= 1'b0;
      sdo_out  <= 1'b0;
      sdo_oe   <= 1'b0;
    end else begin
      sdio_out <= read_bit_i;
      sdio_oe  <= read_bit_en_i && !unidir;
      sdo_out  <= read_bit_i;
      sdo_oe   <= read_bit_en_i && unidir;
    end
  end

  assign reg_rdata_o  = rdata;
  assign reg_rvalid_o = rvalid;

  assign data_pin_o               = sdio_out;
  assign data_pin_oe_o            = sdio_oe;
  assign serial_data_out_pin_o    = sdo_out;
  assign serial_data_out_pin_oe_o = sdo_oe;

  // Decode from the low nibble so mirrored writes act alike in either order
  assign long_instruction_o =
    serial_port_config[ccr_pkg::CFG_LONG_INSTR];
  assign lsb_first_o =
    serial_port_config[ccr_pkg::CFG_LSB_FIRST];
  assign address_increment_o =
    serial_port_config[ccr_pkg::CFG_LSB_FIRST];
  assign unidirectional_read_select_o = unidir;
  assign soft_reset_o   = soft_reset;
  assign update_pulse_o = update_fire;

  assign vco_divide_ratio_o = act_val[ccr_pkg::IDX_VCO];
  assign skip_oscillator_divide_o =
    act_val[ccr_pkg::IDX_CLK][ccr_pkg::CLK_SKIP_DIVIDE];
  assign clock_input_powerdown_o =
    act_val[ccr_pkg::IDX_CLK][ccr_pkg::CLK_POWERDOWN];
  assign powerdown_and_sync_o = act_val[ccr_pkg::IDX_PDS];
  assign soft_sync_o =
    act_val[ccr_pkg::IDX_PDS][ccr_pkg::PDS_SOFT_SYNC];
  assign powerdown_distribution_ref_o =
    act_val[ccr_pkg::IDX_PDS][ccr_pkg::PDS_PD_DIST_REF];
  assign powerdown_sync_o =
    act_val[ccr_pkg::IDX_PDS][ccr_pkg::PDS_PD_SYNC];

endmodule

// ===== verif/ccr_regs_asserts.sv
`timescale 1ns/1ps
module ccr_regs_chk #(
  parameter logic [7:0] PART_IDENTIFIER = 8'h5A
) (
  input logic       ref_clk_i,
  input logic       rst_n_i,
  input logic [9:0] reg_addr_i,
  input logic [7:0] reg_wdata_i,
  input logic       reg_wr_i,
  input logic       reg_rd_i,
  input logic [7:0] reg_rdata_o,
  input logic       reg_rvalid_o,
  input logic       read_bit_i,
  input logic       read_bit_en_i,
  input logic       data_pin_o,
  input logic       data_pin_oe_o,
  input logic       serial_data_out_pin_oe_o,
  input logic       long_instruction_o,
  input logic       lsb_first_o,
  input logic       address_increment_o,
  input logic       unidirectional_read_select_o,
  input logic       soft_reset_o,
  input logic       update_pulse_o,
  input logic [7:0] vco_divide_ratio_o,
  input logic [7:0] powerdown_and_sync_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_upd_req;
    reg_wr_i && reg_addr_i == 10'h232 && reg_wdata_i[0] && !soft_reset_o;
  endsequence
  sequence s_upd_fire;
    update_pulse_o ##1 !update_pulse_o;
  endsequence
  a_long_mode_held:
    assert property (long_instruction_o) else $error("long mode low");
  a_bit_order_set:
    assert property (reg_wr_i && reg_addr_i == 10'h000 |=>
      lsb_first_o == |($past(reg_wdata_i) & 8'h02) &&
      address_increment_o == lsb_first_o) else $error("bit order wrong");
  a_soft_reset_hold:
    assert property (soft_reset_o [*2] |-> vco_divide_ratio_o == 8'h02 &&
      powerdown_and_sync_o == 8'h00) else $error("soft reset missed");
  a_read_pin_pick:
    assert property (read_bit_en_i |=> $past(unidirectional_read_select_o)
      ? serial_data_out_pin_oe_o && !data_pin_oe_o
      : data_pin_oe_o && !serial_data_out_pin_oe_o &&
        data_pin_o == $past(read_bit_i)) else $error("read pin wrong");
  a_pins_idle:
    assert property (!read_bit_en_i |=> !data_pin_oe_o &&
      !serial_data_out_pin_oe_o) else $error("pin enabled when idle");
  a_part_identifier_read:
    assert property (reg_rd_i && !reg_wr_i && reg_addr_i == 10'h003 |=>
      reg_rvalid_o && reg_rdata_o == PART_IDENTIFIER) else $error("bad part_identifier");
  a_update_self_clear:
    assert property (s_upd_req |=> s_upd_fire) else $error("update pulse");
  a_active_on_update:
    assert property ($changed(vco_divide_ratio_o) |->
      $past(update_pulse_o) || $past(soft_reset_o))
      else $error("active changed without update");
endmodule
bind ccr_regs ccr_regs_chk #(.PART_IDENTIFIER(PART_IDENTIFIER)) i_chk (.*);

// ===== verif/ccr_host.sv
`timescale 1ns/1ps
module ccr_host (
  input  logic       ref_clk_i,
  input  logic [7:0] reg_rdata_o,
  input  logic       reg_rvalid_o,
  output logic [9:0] reg_addr_i,
  output logic [7:0] reg_wdata_i,
  output logic       reg_wr_i,
  output logic       reg_rd_i,
  output logic       read_bit_i,
  output logic       read_bit_en_i
);
  // Idle bus from time zero so reset release sees no unknown strobes
  initial begin
    reg_addr_i    <= 10'h000;
    reg_wdata_i   <= 8'h00;
    reg_wr_i      <= 1'b0;
    reg_rd_i      <= 1'b0;
    read_bit_i    <= 1'b0;
    read_bit_en_i <= 1'b0;
  end
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b0;
    reg_wdata_i <= ~v;
  endtask
  // Mirrored nibble decodes the same in either bit order
  task automatic cfg(input logic [3:0] lo);
    wr(10'h000, {lo[0], lo[1], lo[2], 1'b1, 1'b1, lo[2:0]});
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    for (int n = 0; n < 4 && reg_rvalid_o !== 1'b1; n++)
      @(posedge ref_clk_i);
    v = reg_rdata_o;
  endtask
  task automatic rbit(input logic b);
    @(posedge ref_clk_i);
    read_bit_en_i <= 1'b1;
    read_bit_i    <= b;
    @(posedge ref_clk_i);
    read_bit_en_i <= 1'b0;
    read_bit_i    <= ~b;
  endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       ref_clk_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic [9:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [7:0] vco_divide_ratio_o, powerdown_and_sync_o;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, read_bit_i, read_bit_en_i;
  logic data_pin_o, data_pin_oe_o, serial_data_out_pin_o;
  logic serial_data_out_pin_oe_o, long_instruction_o, lsb_first_o;
  logic address_increment_o, unidirectional_read_select_o, soft_reset_o;
  logic update_pulse_o, skip_oscillator_divide_o, clock_input_powerdown_o;
  logic soft_sync_o, powerdown_distribution_ref_o, powerdown_sync_o;
  int         miscompares = 0;
  int         comparisons = 0;
  logic [7:0] d;
  ccr_regs i_dut (.*);
  ccr_host i_host (.*);
  initial forever #50 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string n, input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
    i_host.rd(a, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask
  task automatic t_defaults;
    rchk(10'h000, 8'h18);
    rchk(10'h004, 8'h00);
    rchk(10'h1E0, 8'h02);
    rchk(10'h1E1, 8'h00);
    rchk(10'h230, 8'h00);
    rchk(10'h232, 8'h00);
    $display("defaults done");
  endtask
  task automatic t_part_identifier;
    i_host.wr(10'h003, 8'hFF);
    rchk(10'h003, ccr_pkg::PART_IDENTIFIER_DEFAULT);
    rchk(10'h3FF, 8'h00);
    $display("part_identifier done");
  endtask
  task automatic t_update;
    i_host.wr(10'h1E0, 8'h05);
    i_host.wr(10'h230, 8'h06);
    i_host.wr(10'h1E1, 8'h10);
    rchk(10'h1E0, 8'h05);
    chk("vco out", vco_divide_ratio_o, 8'h02);
    i_host.wr(10'h004, 8'h01);
    rchk(10'h1E0, 8'h02);
    i_host.wr(10'h232, 8'h01);
    repeat (3) @(posedge ref_clk_i);
    chk("vco out", vco_divide_ratio_o, 8'h05);
    chk("pds out", powerdown_and_sync_o, 8'h06);
    chk("pds bits", {5'h00, powerdown_sync_o,
      powerdown_distribution_ref_o, soft_sync_o}, 8'h06);
    chk("clk in", {6'h00, skip_oscillator_divide_o,
      clock_input_powerdown_o}, 8'h01);
    rchk(10'h232, 8'h00);
    rchk(10'h230, 8'h06);
    $display("update done");
  endtask
  task automatic t_config;
    i_host.cfg(4'h2);
    @(posedge ref_clk_i);
    chk("order", {6'h00, lsb_first_o, address_increment_o}, 8'h03);
    rchk(10'h000, 8'h5A);
    i_host.rbit(1'b1);
    @(posedge ref_clk_i);
    chk("bidir", {5'h00, data_pin_oe_o, serial_data_out_pin_oe_o,
      data_pin_o}, 8'h05);
    i_host.cfg(4'h1);
    i_host.rbit(1'b1);
    @(posedge ref_clk_i);
    chk("unidir", {5'h00, data_pin_oe_o, serial_data_out_pin_oe_o,
      serial_data_out_pin_o}, 8'h03);
    $display("config done");
  endtask
  task automatic t_soft_reset;
    i_host.cfg(4'h4);
    i_host.wr(10'h1E0, 8'h09);
    rchk(10'h1E0, 8'h02);
    chk("vco out", vco_divide_ratio_o, 8'h02);
    chk("pds out", powerdown_and_sync_o, 8'h00);
    chk("clk in", {6'h00, skip_oscillator_divide_o,
      clock_input_powerdown_o}, 8'h00);
    rchk(10'h000, 8'h3C);
    i_host.cfg(4'h0);
    rchk(10'h004, 8'h00);
    rchk(10'h230, 8'h00);
    $display("soft reset done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_defaults;
    t_part_identifier;
    t_update;
    t_config;
    t_soft_reset;
    report_and_stop;
  end
  // Run needs about a hundred cycles; generous margin
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    miscompares++;
    report_and_stop;
  end
endmodule
